// [pkg/sld_pkg.sv]
// Shared constants for the serial latched driver and its controller
package sld_pkg;
  localparam int CHANNELS = 32;
  localparam int CLK_PERIOD_NS = 4;
  // Least wait from last shift clock to latch enable
  localparam int STROBE_WAIT_NS = 300;
  localparam int STROBE_WAIT_CYC = (STROBE_WAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Least latch-enable pulse width
  localparam int STROBE_WIDTH_NS = 100;
  localparam int STROBE_WIDTH_CYC = (STROBE_WIDTH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Least shift clock half period for 3.3 MHz
  localparam int SCLK_HALF_NS = 152;
  localparam int SCLK_HALF_CYC = (SCLK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TIMER_W = 8;
  localparam logic [31:0] LATCH_RESET = 32'h0000_0000;
endpackage

// [pkg/sld_link_if.sv]
// Pin-level link between controller and driver
`timescale 1ns/1ns
interface sld_link_if;
  logic ser_in;
  logic shift_clk;
  logic latch_en;
  logic out_disable;
  logic ser_out;
  modport driver (input ser_in, input shift_clk, input latch_en, input out_disable, output ser_out);
  modport controller (output ser_in, output shift_clk, output latch_en, output out_disable, input ser_out);
endinterface

// [hw/sld_controller.sv]
// Controller end: loads words from a two-entry buffer and shifts them out
`timescale 1ns/1ns
module sld_controller
  import sld_pkg::*;
#(
  parameter int WIDTH = CHANNELS
) (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic clk_en,
  input wire logic [WIDTH-1:0] word_data,
  input wire logic word_valid,
  output logic word_ready,
  input wire logic blank_req,
  input wire logic keep_transparent,
  output logic busy,
  sld_link_if.controller link
);
  if (WIDTH < 2 || WIDTH >= (1 << TIMER_W)) begin : g_width_bad
    $error("WIDTH out of range");
  end
  // Driver needs each shift clock phase at least three cycles long
  if (SCLK_HALF_CYC < 3 || STROBE_WAIT_CYC >= (1 << TIMER_W)) begin : g_timing_bad
    $error("Timing counts do not fit");
  end

  typedef enum logic [2:0] {IDLE, LOW, HIGH, WAIT, STROBE} phase_t;

  typedef struct packed {
    logic [1:0][WIDTH-1:0] buf_data;
    logic [1:0] buf_full;
    logic buf_rd;
    logic buf_wr;
    phase_t phase;
    logic [WIDTH-1:0] shreg;
    logic [TIMER_W-1:0] bits;
    logic [TIMER_W-1:0] timer;
    logic ser_in;
    logic shift_clk;
    logic latch_en;
    logic out_disable;
  } ctrl_state_t;

  ctrl_state_t s, next_s;

  assign word_ready = !s.buf_full[s.buf_wr];
  assign busy = (s.phase != IDLE) || (s.buf_full != 2'b00);
  assign link.ser_in = s.ser_in;
  assign link.shift_clk = s.shift_clk;
  assign link.latch_en = s.latch_en;
  assign link.out_disable = s.out_disable;

  always_comb begin
    next_s = s;
    if (word_valid && word_ready) begin
      next_s.buf_data[s.buf_wr] = word_data;
      next_s.buf_full[s.buf_wr] = 1'b1;
      next_s.buf_wr = !s.buf_wr;
    end
    // Blank the outputs while shifting with keep_transparent high
    next_s.out_disable = blank_req || (keep_transparent && s.phase != IDLE);
    case (s.phase)
      IDLE: begin
        next_s.latch_en = keep_transparent;
        if (s.buf_full[s.buf_rd]) begin
          next_s.buf_full[s.buf_rd] = 1'b0;
          next_s.buf_rd = !s.buf_rd;
          next_s.shreg = s.buf_data[s.buf_rd];
          next_s.bits = TIMER_W'(WIDTH);
          next_s.timer = TIMER_W'(SCLK_HALF_CYC);
          next_s.ser_in = s.buf_data[s.buf_rd][WIDTH-1];
          next_s.out_disable = blank_req || keep_transparent;
          next_s.phase = LOW;
        end
      end
      LOW: begin
        if (s.timer > 1) begin
          next_s.timer = s.timer - 1'b1;
        end else begin
          next_s.shift_clk = 1'b1;
          next_s.timer = TIMER_W'(SCLK_HALF_CYC);
          next_s.bits = s.bits - 1'b1;
          next_s.phase = HIGH;
        end
      end
      HIGH: begin
        if (s.timer > 1) begin
          next_s.timer = s.timer - 1'b1;
        end else begin
          next_s.shift_clk = 1'b0;
          next_s.shreg = {s.shreg[WIDTH-2:0], 1'b0};
          next_s.ser_in = s.shreg[WIDTH-2];
          next_s.timer = TIMER_W'(s.bits == 0 ? STROBE_WAIT_CYC : SCLK_HALF_CYC);
          next_s.phase = (s.bits == 0) ? WAIT : LOW;
        end
      end
      WAIT: begin
        if (s.timer > 1) begin
          next_s.timer = s.timer - 1'b1;
        end else begin
          next_s.latch_en = 1'b1;
          next_s.timer = TIMER_W'(STROBE_WIDTH_CYC);
          next_s.phase = STROBE;
        end
      end
      default: begin
        if (s.timer > 1) begin
          next_s.timer = s.timer - 1'b1;
        end else begin
          next_s.latch_en = keep_transparent;
          next_s.phase = IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      s <= '0;
      s.phase <= IDLE;
      s.out_disable <= 1'b1;
    end else if (clk_en) begin
      s <= next_s;
    end
  end
endmodule // sld_controller

// [hw/sld_driver.sv]
// Driver end: 32-stage shift register, latches and output stage
`timescale 1ns/1ns
// Summary of operation
// - Rising clock captures serial input into stage one
// - Later edges move each bit one stage on
// - Serial output carries shifted bits for chaining
// - Thirty-two stages, latches and drivers
// - Latch-enable high is transparent, low holds
// - Disable high: sources off, sinks on
// - Disable never alters latch contents
// - Enabled outputs follow latches high or low
// - Controller blanks outputs while a frame shifts with keep_transparent held high
// - Controller waits 300 ns before latch-enable, which stays high all frame with keep_transparent high
// - Latch-enable pulse lasts at least 100 ns
// - Shift clock no faster than 3.3 MHz
module sld_driver
  import sld_pkg::*;
#(
  parameter int WIDTH = CHANNELS
) (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic clk_en,
  sld_link_if.driver link,
  output logic [WIDTH-1:0] out_source,
  output logic [WIDTH-1:0] out_sink,
  output logic [WIDTH-1:0] latched
);
  if (WIDTH < 2) begin : g_width_bad
    $error("WIDTH must be at least 2");
  end

  typedef struct packed {
    logic [1:0][3:0] sync;
    logic clk_prev;
    logic [WIDTH-1:0] shreg;
    logic [WIDTH-1:0] latch;
    logic [WIDTH-1:0] source;
    logic [WIDTH-1:0] sink;
  } drv_state_t;

  drv_state_t s, next_s;
  logic rise;
  logic din, clk_s, le_s, dis_s;

  // Stage 0 first flop, stage 1 second flop, read only from stage 1
  assign din = s.sync[1][0];
  assign clk_s = s.sync[1][1];
  assign le_s = s.sync[1][2];
  assign dis_s = s.sync[1][3];
  assign rise = clk_s && !s.clk_prev;
  assign link.ser_out = s.shreg[WIDTH-1];
  assign out_source = s.source;
  assign out_sink = s.sink;
  assign latched = s.latch;

  always_comb begin
    next_s = s;
    next_s.sync[0] = {link.out_disable, link.latch_en, link.shift_clk, link.ser_in};
    next_s.sync[1] = s.sync[0];
    next_s.clk_prev = clk_s;
    if (rise) begin
      next_s.shreg = {s.shreg[WIDTH-2:0], din};
    end
    if (le_s) begin
      next_s.latch = s.shreg;
    end
    if (dis_s) begin
      next_s.source = '0;
      next_s.sink = '1;
    end else begin
      next_s.source = s.latch;
      next_s.sink = ~s.latch;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      s <= '0;
      s.latch <= LATCH_RESET;
      s.sink <= '1;
    end else if (clk_en) begin
      s <= next_s;
    end
  end
endmodule // sld_driver

// [tb/sld_chk.sv]
// Link assertions for the controller and driver pair
`timescale 1ns/1ns
module sld_chk
  import sld_pkg::*;
(
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic ser_in,
  input wire logic shift_clk,
  input wire logic latch_en,
  input wire logic out_disable,
  input wire logic ser_out
);
  logic [7:0] cnt;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (srst);
  // Cycles since last shift clock or latch edge
  always_ff @(posedge sys_clk) begin
    if (srst) cnt <= 8'hff;
    else if ($changed({shift_clk, latch_en})) cnt <= 8'h00;
    else if (cnt != 8'hff) cnt <= cnt + 8'h01;
  end
  property p_rst; $fell(srst) |-> out_disable && !latch_en && !shift_clk && !ser_out; endproperty
  a_rst: assert property (p_rst) else $error("link busy at reset");
  property p_half; $changed(shift_clk) |-> cnt >= SCLK_HALF_CYC - 1; endproperty
  a_half: assert property (p_half) else $error("shift phase short");
  property p_wait; $rose(latch_en) |-> cnt >= STROBE_WAIT_CYC - 1; endproperty
  a_wait: assert property (p_wait) else $error("latch too early");
  property p_width; $fell(latch_en) |-> cnt >= STROBE_WIDTH_CYC - 1; endproperty
  a_width: assert property (p_width) else $error("latch pulse short");
  property p_blank; latch_en && $rose(shift_clk) |-> out_disable; endproperty
  a_blank: assert property (p_blank) else $error("shift not blanked");
  property p_sout; $changed(ser_out) |-> shift_clk && cnt < 8'd8; endproperty
  a_sout: assert property (p_sout) else $error("serial out moved");
  property p_setup; $changed(ser_in) |-> !shift_clk; endproperty
  a_setup: assert property (p_setup) else $error("data moved high");
  property p_lelow; $rose(latch_en) |-> !shift_clk; endproperty
  a_lelow: assert property (p_lelow) else $error("latch in shift");
  c_latch: cover property ($rose(latch_en));
  c_trans: cover property (latch_en && $rose(shift_clk));
  c_sout: cover property ($changed(ser_out));
endmodule // sld_chk

// [tb/serial_latched_driver_32_tb.sv]
// Bench for the controller and driver pair
`timescale 1ns/1ns
module serial_latched_driver_32_tb;
  logic sys_clk = 0, srst = 1, word_valid = 0, blank_req = 0, keep_transparent = 0, busy, word_ready;
  logic [31:0] word_data = 32'h0, src, snk, lat;
  logic clk_en = 1'b1;
  int bad_count = 0, checked = 0;
  // Word with expected serial out bit above it
  logic [32:0] rows [4] = '{{1'b1, 32'h8000_0001}, {1'b0, 32'h7fff_fffe}, {1'b1, 32'hffff_ffff}, 33'h0};
  always #2 sys_clk = ~sys_clk;
  sld_link_if link();
  sld_controller u_sld_controller(.sys_clk, .srst, .clk_en, .word_data, .word_valid, .word_ready,
    .blank_req, .keep_transparent, .busy, .link);
  sld_driver u_sld_driver(.sys_clk, .srst, .clk_en, .link, .out_source(src), .out_sink(snk), .latched(lat));
  sld_chk u_sld_chk(.sys_clk, .srst, .ser_in(link.ser_in), .shift_clk(link.shift_clk),
    .latch_en(link.latch_en), .out_disable(link.out_disable), .ser_out(link.ser_out));
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task wt(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task send(input logic [31:0] w);
    word_data = w;
    word_valid = 1'b1;
    while (word_ready !== 1'b1) wt(1);
    wt(1);
  endtask
  task idle;
    for (int i = 0; i < 6000 && busy !== 1'b0; i++) wt(1);
    chk({31'h0, busy}, 32'h0);
    wt(100);
  endtask
  task frame(input logic [32:0] r);
    chk(lat, r[31:0]);
    chk(src, r[31:0]);
    chk(snk, ~r[31:0]);
    chk({31'h0, link.ser_out}, {31'h0, r[32]});
  endtask
  task results;
    $display("checked=%0d bad_count=%0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    wt(20);
    chk(lat, 32'h0);
    chk(snk, 32'hffff_ffff);
    chk({30'h0, word_ready, link.out_disable}, 32'h3);
    srst = 1'b0;
    foreach (rows[i]) begin
      send(rows[i][31:0]);
      word_valid = 1'b0;
      idle;
      frame(rows[i]);
    end
    // Back to back words through the buffer
    send(32'h1234_5678);
    send(32'ha5a5_0ff0);
    word_valid = 1'b0;
    idle;
    idle;
    frame({1'b1, 32'ha5a5_0ff0});
    blank_req = 1'b1;
    wt(8);
    chk(src, 32'h0);
    chk(snk, 32'hffff_ffff);
    chk(lat, 32'ha5a5_0ff0);
    blank_req = 1'b0;
    wt(8);
    chk(src, 32'ha5a5_0ff0);
    // Clock enable low freezes both ends
    clk_en = 1'b0;
    blank_req = 1'b1;
    wt(8);
    chk(src, 32'ha5a5_0ff0);
    clk_en = 1'b1;
    wt(8);
    chk(src, 32'h0);
    blank_req = 1'b0;
    wt(8);
    chk(src, 32'ha5a5_0ff0);
    keep_transparent = 1'b1;
    send(32'h0f0f_3c3c);
    word_valid = 1'b0;
    wt(300);
    chk(src, 32'h0);
    idle;
    frame({1'b0, 32'h0f0f_3c3c});
    keep_transparent = 1'b0;
    wt(100);
    // Reset in mid-frame, then one more frame
    send(32'hc3c3_5a5a);
    word_valid = 1'b0;
    wt(500);
    srst = 1'b1;
    wt(5);
    srst = 1'b0;
    chk(lat, 32'h0);
    chk(snk, 32'hffff_ffff);
    chk({31'h0, link.ser_out}, 32'h0);
    chk({30'h0, word_ready, busy}, 32'h2);
    send(rows[0][31:0]);
    word_valid = 1'b0;
    idle;
    frame(rows[0]);
    results;
  end
  initial begin
    #200000;
    bad_count++;
    results;
  end
endmodule // serial_latched_driver_32_tb
